// >>> accumulator_shifted_add_unit.sv
// Shifted-add datapath with four 40-bit accumulators, carry and overflow flags.
// Assumes the decoder presents one operation per cycle, same clock domain.
//
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module accumulator_shifted_add_unit
    import acc_shadd_pkg::*;
(
    input  wire logic              sys_clk_in,              // Core clock
    input  wire logic              srst_in,                 // Sync reset, high
    input  wire logic              op_valid_in,             // Operation strobe
    input  wire logic [2:0]        op_form_in,              // Form code
    input  wire logic [1:0]        op_src_in,               // Source accumulator
    input  wire logic [1:0]        op_dst_in,               // Destination accumulator
    input  wire logic [15:0]       temp_reg_in,             // Temporary register value
    input  wire logic [15:0]       signed_immediate_sixteen_in, // 16-bit immediate
    input  wire logic [5:0]        six_bit_shift_immediate_in,  // Signed count
    input  wire logic [3:0]        four_bit_shift_immediate_in, // Unsigned count
    input  wire logic [15:0]       mem_word_in,             // Memory operand
    input  wire logic              uns_in,                  // Unsigned qualifier
    input  wire logic [3:0]        avs_address_in,          // Byte address
    input  wire logic              avs_read_in,             // Read request
    input  wire logic              avs_write_in,            // Write request
    input  wire logic [31:0]       avs_writedata_in,        // Write data
    output logic [31:0]            avs_readdata_out,        // Read data
    output logic                   avs_waitrequest_out,     // Wait request
    output logic                   res_valid_out,           // Result written
    output logic [1:0]             res_dst_out,             // Written accumulator
    output logic [ACC_W-1:0]       res_acc_out,             // Written value
    output logic                   carry_out,               // Carry flag
    output logic [3:0]             accumulator_overflow_flag_out, // Per accumulator
    output logic                   irq_out                  // Interrupt level
);
    logic [ACC_W-1:0] acc_q [4];
    logic [ACC_W-1:0] acc_d [4];
    logic [4:0]       mode_q, mode_d;
    logic [ST_W-1:0]  status_q, status_d, mask_q, mask_d;
    logic             res_valid_q, res_valid_d, irq_q, irq_d;
    logic [1:0]       res_dst_q, res_dst_d;
    logic [ACC_W-1:0] res_acc_q, res_acc_d;
    logic [31:0]      rdata_q, rdata_d;
    logic             wait_q, wait_d;

    logic             sxm, m40, datapath_saturation_mode, legacy, m40_shift;
    logic             req, bus_take, bus_wr_mode;
    logic [ACC_W-1:0] base, opnd, shifted, result;
    logic [ACC_W-1:0] mem_ext, k16_ext, src_acc;
    logic signed [5:0] raw_cnt, cnt;
    logic             shift_ovf, ovf, carry_new, cin, op_ok, is_mem_hi, tx_form;
    logic [ACC_W:0]   sum, usum40;
    logic [32:0]      usum32;

    assign sxm = mode_q[SXM_BIT];
    assign m40 = mode_q[M40_BIT];
    assign datapath_saturation_mode = mode_q[SAT_BIT];
    assign legacy = mode_q[LEG_BIT];
    assign m40_shift = m40 | legacy;
    assign src_acc = acc_q[op_src_in];
    assign op_ok = op_valid_in && (op_form_in <= F_MEM_C);
    assign is_mem_hi = op_form_in == F_MEM_HI;
    assign tx_form = op_form_in == F_ACC_TX || op_form_in == F_MEM_TX;

    assign k16_ext = sxm ? {{24{signed_immediate_sixteen_in[15]}}, signed_immediate_sixteen_in}
                         : {24'h000000, signed_immediate_sixteen_in};
    assign mem_ext = (sxm && !(uns_in && op_form_in == F_MEM_C))
                   ? {{24{mem_word_in[15]}}, mem_word_in} : {24'h000000, mem_word_in};

    always_comb begin
        raw_cnt = signed'(temp_reg_in[5:0]);
        base = src_acc;
        opnd = mem_ext;
        cin = 1'b0;
        case (op_form_in)
            F_ACC_TX: begin
                base = acc_q[op_dst_in];
                opnd = src_acc;
            end
            F_ACC_IMM: begin
                base = acc_q[op_dst_in];
                opnd = src_acc;
                raw_cnt = signed'(six_bit_shift_immediate_in);
            end
            F_K16_HI: begin
                opnd = k16_ext;
                raw_cnt = signed'(HI_SHIFT);
            end
            F_K16_SH: begin
                opnd = k16_ext;
                raw_cnt = signed'({2'b00, four_bit_shift_immediate_in});
            end
            F_MEM_TX: opnd = mem_ext;
            F_MEM_HI: raw_cnt = signed'(HI_SHIFT);
            F_MEM_C: begin
                raw_cnt = 6'sd0;
                cin = mode_q[CARRY_BIT];
            end
            default: opnd = mem_ext;
        endcase
    end

    // Legacy count folding.
    // Only a temporary-register count folds; immediate counts pass unchanged.
    assign cnt = (legacy && tx_form && raw_cnt[5:4] == 2'b10)
               ? raw_cnt + signed'(LEGACY_ADJ) : raw_cnt;

    always_comb begin
        if (cnt >= 0) begin
            shifted = opnd << cnt;
            shift_ovf = ($signed(shifted) >>> cnt) != $signed(opnd);
            if (!m40_shift)
                shift_ovf = shift_ovf | !(&shifted[39:31] | ~|shifted[39:31]);
        end else begin
            shifted = ACC_W'($signed(opnd) >>> (-cnt));
            shift_ovf = 1'b0;
        end
        if (legacy)
            shift_ovf = 1'b0;
    end

    assign sum = {base[39], base} + {shifted[39], shifted} + {40'h0, cin};
    assign usum40 = {1'b0, base} + {1'b0, shifted} + {40'h0, cin};
    assign usum32 = {1'b0, base[31:0]} + {1'b0, shifted[31:0]} + {32'h0, cin};

    always_comb begin
        if (m40) begin
            ovf = (sum[40] != sum[39]) | shift_ovf;
            carry_new = usum40[40];
        end else begin
            ovf = !(&sum[40:31] | ~|sum[40:31]) | shift_ovf;
            carry_new = usum32[32];
        end
        result = sum[39:0];
        if (ovf && datapath_saturation_mode) begin
            if (m40)
                result = sum[40] ? SAT_NEG40 : SAT_POS40;
            else
                result = sum[40] ? SAT_NEG32 : SAT_POS32;
        end
    end

    assign req = avs_read_in | avs_write_in;
    assign bus_take = req & !wait_q;
    assign bus_wr_mode = bus_take && avs_write_in && avs_address_in == MODE_OFS;

    always_comb begin
        for (int i = 0; i < 4; i++)
            acc_d[i] = acc_q[i];
        mode_d = mode_q;
        status_d = status_q;
        mask_d = mask_q;
        res_valid_d = op_ok;
        res_dst_d = res_dst_q;
        res_acc_d = res_acc_q;
        wait_d = !(req && wait_q);
        rdata_d = rdata_q;
        if (req && wait_q) begin
            case (avs_address_in)
                MODE_OFS:   rdata_d = {27'h0, mode_q};
                STATUS_OFS: rdata_d = {27'h0, status_q};
                MASK_OFS:   rdata_d = {27'h0, mask_q};
                default:    rdata_d = 32'h0000_0000;
            endcase
        end
        if (bus_take && avs_write_in) begin
            case (avs_address_in)
                MODE_OFS:   mode_d = avs_writedata_in[4:0];
                STATUS_OFS: status_d = status_q & ~avs_writedata_in[ST_W-1:0];
                MASK_OFS:   mask_d = avs_writedata_in[ST_W-1:0];
                default:    mode_d = mode_q;
            endcase
        end
        if (op_ok) begin
            acc_d[op_dst_in] = result;
            res_dst_d = op_dst_in;
            res_acc_d = result;
            if (!is_mem_hi || carry_new)
                mode_d[CARRY_BIT] = carry_new;
            // Hardware set wins over a same-cycle clear.
            if (ovf && !(legacy && shift_ovf))
                status_d[op_dst_in] = 1'b1;
            if (carry_new)
                status_d[4] = 1'b1;
        end
        irq_d = |(status_q & mask_q);
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            for (int i = 0; i < 4; i++)
                acc_q[i] <= '0;
            mode_q <= MODE_RST;
            status_q <= STATUS_RST;
            mask_q <= MASK_RST;
            res_valid_q <= 1'b0;
            res_dst_q <= 2'h0;
            res_acc_q <= '0;
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            irq_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            mode_q <= mode_d;
            status_q <= status_d;
            mask_q <= mask_d;
            res_valid_q <= res_valid_d;
            res_dst_q <= res_dst_d;
            res_acc_q <= res_acc_d;
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    assign avs_readdata_out = rdata_q;
    assign avs_waitrequest_out = wait_q;
    assign res_valid_out = res_valid_q;
    assign res_dst_out = res_dst_q;
    assign res_acc_out = res_acc_q;
    assign carry_out = mode_q[CARRY_BIT];
    assign accumulator_overflow_flag_out = status_q[3:0];
    assign irq_out = irq_q;

    a_result_next: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        op_ok |=> res_valid_q && res_dst_q == $past(op_dst_in))
        else $error("result not presented one cycle after the operation");
    a_acc_written: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        res_valid_q |-> acc_q[res_dst_q] == res_acc_q)
        else $error("accumulator does not hold the presented result");
    a_memhi_carry: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        op_ok && is_mem_hi && !carry_new && !bus_wr_mode |=> $stable(mode_q[CARRY_BIT]))
        else $error("high-half form cleared the carry");
    a_sat_bound: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        op_ok && ovf && datapath_saturation_mode && m40 |=> res_acc_q == SAT_POS40 || res_acc_q == SAT_NEG40)
        else $error("wide overflow not saturated");
    a_nosat_raw: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        op_ok && !datapath_saturation_mode |=> res_acc_q == $past(sum[39:0]))
        else $error("unsaturated result differs from sum");
    a_legacy_fold: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        legacy && tx_form && raw_cnt < -16 |-> cnt == raw_cnt + 6'sd16)
        else $error("legacy count not folded");
    a_imm_nofold: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        !(legacy && tx_form) |-> cnt == raw_cnt)
        else $error("count folded outside a legacy register-count form");
    a_uns_zero: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        op_form_in == F_MEM_C && uns_in |-> mem_ext[39:16] == 24'h000000)
        else $error("unsigned memory operand not zero-extended");
    a_legacy_noshov: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        legacy |-> !shift_ovf)
        else $error("shift overflow reported in legacy mode");
    a_ovf_flag: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        op_ok && ovf |=> accumulator_overflow_flag_out[$past(op_dst_in)])
        else $error("overflow flag not set");
    a_wait_one: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        req && wait_q |=> !wait_q ##1 wait_q)
        else $error("waitrequest not one cycle");
    a_sat_narrow: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        op_ok && ovf && datapath_saturation_mode && !m40 |=> res_acc_q == SAT_POS32 || res_acc_q == SAT_NEG32)
        else $error("narrow overflow not saturated");
    a_carry_follow: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        op_ok && !is_mem_hi |=> carry_out == $past(carry_new))
        else $error("carry flag does not follow the computed carry");
    a_memhi_set: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        op_ok && is_mem_hi && carry_new |=> carry_out)
        else $error("high-half form did not set the carry");
    a_uns_signed: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        sxm && !(op_form_in == F_MEM_C && uns_in) |-> mem_ext[39:16] == {24{mem_word_in[15]}})
        else $error("signed memory operand not sign-extended");
    a_k16_ext: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        sxm |-> k16_ext[39:16] == {24{signed_immediate_sixteen_in[15]}})
        else $error("immediate not sign-extended");
    a_refused_quiet: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        op_valid_in && !op_ok |=> !res_valid_q)
        else $error("refused form produced a result");
    a_res_hold: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        !op_ok |=> $stable(res_dst_q) && $stable(res_acc_q))
        else $error("result changed without an operation");
    a_irq_level: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        1'b1 |=> irq_out == $past(|(status_q & mask_q)))
        else $error("interrupt level does not follow masked status");
    a_w1c_clear: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        bus_take && avs_write_in && avs_address_in == STATUS_OFS && !op_ok
        |=> (status_q & $past(avs_writedata_in[ST_W-1:0])) == '0)
        else $error("status bits not cleared by a one");
    a_mask_read: assert property (@(posedge sys_clk_in) disable iff (srst_in)
        req && wait_q && avs_address_in == MASK_OFS |=> avs_readdata_out == {27'h0, $past(mask_q)})
        else $error("mask read data wrong");
    c_memhi_carry: cover property (@(posedge sys_clk_in) op_ok && is_mem_hi && carry_new);
    c_wide_raw_ovf: cover property (@(posedge sys_clk_in) op_ok && ovf && m40 && !datapath_saturation_mode);
    c_saturate: cover property (@(posedge sys_clk_in) op_ok && ovf && datapath_saturation_mode);
    c_legacy_fold: cover property (@(posedge sys_clk_in) op_ok && legacy && tx_form && raw_cnt < -16);
    c_back_to_back: cover property (@(posedge sys_clk_in) op_ok ##1 op_ok);
endmodule

// >>> acc_shadd_pkg.sv
// Constants for the 40-bit accumulator shifted-add unit.
// Assumes one 100 MHz core clock and an Avalon-MM register slave.
package acc_shadd_pkg;
    localparam int ACC_W = 40;
    localparam int WORD_W = 16;
    // Operation form codes.
    localparam logic [2:0] F_ACC_TX  = 3'h0;
    localparam logic [2:0] F_ACC_IMM = 3'h1;
    localparam logic [2:0] F_K16_HI  = 3'h2;
    localparam logic [2:0] F_K16_SH  = 3'h3;
    localparam logic [2:0] F_MEM_TX  = 3'h4;
    localparam logic [2:0] F_MEM_HI  = 3'h5;
    localparam logic [2:0] F_MEM_C   = 3'h6;
    localparam logic [5:0] HI_SHIFT  = 6'h10;
    localparam logic [5:0] LEGACY_ADJ = 6'h10;
    // Register byte offsets.
    localparam logic [3:0] MODE_OFS   = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] MASK_OFS   = 4'h8;
    // Mode register bit positions.
    localparam int SXM_BIT = 0;
    localparam int M40_BIT = 1;
    localparam int SAT_BIT = 2;
    localparam int LEG_BIT = 3;
    localparam int CARRY_BIT = 4;
    // Status bits 3:0 are accumulator overflow flags, bit 4 a carry-set event.
    localparam int ST_W = 5;
    localparam logic [ST_W-1:0] STATUS_RST = 5'h00;
    localparam logic [ST_W-1:0] MASK_RST = 5'h00;
    localparam logic [4:0] MODE_RST = 5'h01;
    localparam logic [ACC_W-1:0] SAT_POS40 = 40'h7F_FFFF_FFFF;
    localparam logic [ACC_W-1:0] SAT_NEG40 = 40'h80_0000_0000;
    localparam logic [ACC_W-1:0] SAT_POS32 = 40'h00_7FFF_FFFF;
    localparam logic [ACC_W-1:0] SAT_NEG32 = 40'hFF_8000_0000;
endpackage

// >>> op_feeder.sv
// Operation source standing in for the decoder and operand fetch.
// Assumes the bench hands it one packed operation per clock, fields in port order.
`timescale 1ns/1ps
module op_feeder (
    input  wire logic        clk_in, // Core clock
    input  wire logic [66:0] op_in,  // Packed operation from the bench
    output logic [66:0]      op_out  // Registered operation to the unit
);
    always_ff @(posedge clk_in) begin
        op_out <= op_in;
    end
endmodule

// >>> test_accumulator_shifted_add_unit.sv
// Self-checking bench for the shifted-add unit with a reference model.
// Assumes op_feeder sits between the bench and the operation port.
`timescale 1ns/1ps
module test_accumulator_shifted_add_unit;
    import acc_shadd_pkg::*;
    typedef struct packed {
        logic [39:0] r;
        logic        c;
        logic [3:0]  f;
        logic [1:0]  d;
    } exp_s;
    logic        clk = 1'b0, rst = 1'b1, rd_v = 1'b0, wr_v = 1'b0, wait_o, rv_o, c_o, irq_o;
    logic [66:0] op_in = '0, op_q;
    logic [3:0]  adr = 4'h0, fl_o, mode_m = 4'h1;
    logic [31:0] wd = 32'h0, rdat_o, rd, seed = 32'h0001_5A4F;
    logic [1:0]  dst_o;
    logic [39:0] acc_o, acc_m [4] = '{default: '0};
    logic        car_m = 1'b0;
    logic [4:0]  st_m = 5'h00, mk;
    exp_s        exp_q [$], e;
    int          error_cnt = 0, num_checks = 0, cyc = 0;
    accumulator_shifted_add_unit dut (
        .sys_clk_in(clk), .srst_in(rst), .op_valid_in(op_q[66]), .op_form_in(op_q[65:63]),
        .op_src_in(op_q[62:61]), .op_dst_in(op_q[60:59]), .temp_reg_in(op_q[58:43]),
        .signed_immediate_sixteen_in(op_q[42:27]), .six_bit_shift_immediate_in(op_q[26:21]),
        .four_bit_shift_immediate_in(op_q[20:17]), .mem_word_in(op_q[16:1]), .uns_in(op_q[0]),
        .avs_address_in(adr), .avs_read_in(rd_v), .avs_write_in(wr_v), .avs_writedata_in(wd),
        .avs_readdata_out(rdat_o), .avs_waitrequest_out(wait_o), .res_valid_out(rv_o),
        .res_dst_out(dst_o), .res_acc_out(acc_o), .carry_out(c_o),
        .accumulator_overflow_flag_out(fl_o), .irq_out(irq_o));
    op_feeder feed (.clk_in(clk), .op_in(op_in), .op_out(op_q));
    initial forever #5 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        adr <= a;
        wd <= d;
        rd_v <= !w;
        wr_v <= w;
        do @(posedge clk); while (wait_o !== 1'b0);
        rd = rdat_o;
        rd_v <= 1'b0;
        wr_v <= 1'b0;
        @(posedge clk);
    endtask
    task automatic set_mode(input logic [4:0] m);
        bus(1'b1, MODE_OFS, 32'(m));
        {car_m, mode_m} = m;
        bus(1'b0, MODE_OFS, 32'h0);
        cmp(rd, 64'(m));
    endtask
    task automatic issue(input logic [66:0] w);
        logic [2:0]  f;
        logic [1:0]  d;
        logic [39:0] a, b, r;
        logic [79:0] x;
        logic signed [6:0] n;
        logic [40:0] s, cw;
        logic [32:0] cn;
        logic        ov, c, ci;
        f = w[65:63];
        d = w[60:59];
        op_in <= w;
        if (f != 3'h7) begin
            a = (f < 3'h2) ? acc_m[d] : acc_m[w[62:61]];
            if (f < 3'h2) b = acc_m[w[62:61]];
            else if (f < 3'h4) b = {{24{mode_m[0] & w[42]}}, w[42:27]};
            else b = {{24{mode_m[0] & !(f == 3'h6 && w[0]) & w[16]}}, w[16:1]};
            case (f)
                3'h0, 3'h4: n = $signed(w[48:43]);
                3'h1: n = $signed(w[26:21]);
                3'h2, 3'h5: n = 7'sh10;
                3'h3: n = {3'h0, w[20:17]};
                default: n = 7'sh00;
            endcase
            if (mode_m[3] && f[1:0] == 2'h0 && n < -7'sh10) n = n + 7'sh10;
            x = {{40{b[39]}}, b};
            x = (n < 7'sh00) ? x >> (-n) : x << n;
            ov = !mode_m[3] && n > 7'sh00 &&
                 (mode_m[1] ? x[79:39] != {41{x[79]}} : x[79:31] != {49{x[79]}});
            ci = (f == 3'h6) & car_m;
            s = {a[39], a} + {x[39], x[39:0]} + 41'(ci);
            cw = {1'b0, a} + {1'b0, x[39:0]} + 41'(ci);
            cn = {1'b0, a[31:0]} + {1'b0, x[31:0]} + 33'(ci);
            c = mode_m[1] ? cw[40] : cn[32];
            ov = ov | (mode_m[1] ? s[40] != s[39] : s[40:31] != {10{s[40]}});
            r = s[39:0];
            if (ov && mode_m[2]) r = mode_m[1] ? (s[40] ? SAT_NEG40 : SAT_POS40)
                                               : (s[40] ? SAT_NEG32 : SAT_POS32);
            car_m = (f == 3'h5) ? car_m | c : c;
            st_m = st_m | {c, 4'h0} | (5'(ov) << d);
            acc_m[d] = r;
            exp_q.push_back('{r, car_m, st_m[3:0], d});
        end
        @(posedge clk);
    endtask
    task automatic drain();
        op_in <= '0;
        repeat (4) @(posedge clk);
        cmp(exp_q.size(), 64'h0);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            final_report();
        end
        if (rv_o === 1'b1) begin
            cmp(64'(exp_q.size() > 0), 64'h1);
            e = exp_q.size() ? exp_q.pop_front() : '0;
            cmp(acc_o, e.r);
            cmp(dst_o, e.d);
            cmp(c_o, e.c);
            cmp(fl_o, e.f);
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset values of mode, status, mask and an unmapped word.
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 4'(i * 4), 32'h0);
            cmp(rd, 64'(i == 0));
        end
        bus(1'b1, 4'hC, 32'h1F);
        bus(1'b0, 4'hC, 32'h0);
        cmp(rd, 64'h0);
        set_mode(5'h00);
        issue({4'hA, 2'h0, 2'h1, 16'h0, 16'h2300, 27'h0});
        issue({4'hC, 2'h1, 2'h0, 16'h000C, 26'h0, 16'h0300, 1'b0});
        issue({4'hB, 2'h0, 2'h2, 16'h0, 16'hFFFF, 6'h0, 4'hF, 17'h0});
        drain();
        set_mode(5'h09);
        issue({4'h8, 2'h1, 2'h3, 16'h0020, 43'h0});
        issue({4'hE, 2'h0, 2'h1, 42'h0, 16'hFFFF, 1'b1});
        issue({4'hD, 2'h2, 2'h2, 42'h0, 16'hFFFF, 1'b0});
        issue({4'h9, 2'h2, 2'h0, 32'h0, 6'h21, 21'h0});
        drain();
        for (int p = 0; p < 16; p++) begin
            // Low four mode bits walk every combination; the carry bit is random.
            set_mode(5'(rnd()) & 5'h10 | 5'(p));
            repeat (60) issue({1'b1, 2'(rnd()), rnd(), rnd()});
            drain();
            mk = 5'(rnd());
            bus(1'b0, STATUS_OFS, 32'h0);
            cmp(rd, 64'(st_m));
            bus(1'b1, MASK_OFS, 32'(mk));
            @(posedge clk);
            cmp(irq_o, 64'(|(st_m & mk)));
            bus(1'b1, STATUS_OFS, 32'h1F);
            st_m = 5'h00;
            bus(1'b0, STATUS_OFS, 32'h0);
            cmp(64'({rd[4:0], irq_o}), 64'h0);
        end
        final_report();
    end
endmodule
